// [shared/ssg_pkg.sv]
// constants and carriers for the serializer sideband block
package ssg_pkg;
    // clock and timing
    localparam int CLK_NS = 10;
    localparam int BC_LOSS_NS = 20000;
    localparam int BC_LOSS_CYC = BC_LOSS_NS / CLK_NS;
    localparam int BC_LOSS_W = 12;
    // register offsets
    localparam logic [7:0] ADDR_LINK_STAT = 8'h0C;
    localparam logic [7:0] ADDR_PIN0_MODE = 8'h0D;
    localparam logic [7:0] ADDR_PIN12_MODE = 8'h0E;
    localparam logic [7:0] ADDR_PIN3_MODE = 8'h0F;
    localparam logic [7:0] ADDR_REGPIN56 = 8'h10;
    localparam logic [7:0] ADDR_REGPIN78 = 8'h11;
    localparam logic [7:0] ADDR_IN_LVL_LO = 8'h1C;
    localparam logic [7:0] ADDR_IN_LVL_HI = 8'h1D;
    localparam logic [7:0] ADDR_IRQ_CTL = 8'hC6;
    localparam logic [7:0] ADDR_IRQ_STAT = 8'hC7;
    // reset values
    localparam logic [7:0] RST_MODE = 8'h00;
    localparam logic [7:0] RST_IRQ_CTL = 8'h00;
    // field positions
    localparam int BIT_LINK_DET = 0;
    localparam int BIT_HPD_LVL = 1;
    localparam int BIT_IRQ_GLOBAL = 0;
    localparam int BIT_IRQ_LINK = 1;
    localparam int BIT_IRQ_REMOTE = 5;
    localparam int BIT_LVL_REGPIN5 = 5;
    localparam int BIT_LVL_REGPIN8 = 0;
    // pin mode codes
    localparam logic [3:0] MODE_OUT_LOW = 4'h1;
    localparam logic [3:0] MODE_INPUT = 4'h3;
    localparam logic [3:0] MODE_FROM_BACK = 4'h5;
    localparam logic [3:0] MODE_OUT_HIGH = 4'h9;
    // back channel framing
    localparam int BC_FRAME_W = 16;
    localparam logic [3:0] BC_SYNC = 4'hA;
    localparam logic [4:0] BC_CNT_LAST = 5'd15;
    // forward word
    localparam int FWD_W = 35;
    localparam logic [15:0] LFSR_SEED = 16'hACE1;
    // pin synchroniser width
    localparam int SYNC_W = 48;

    typedef struct packed {
        logic [23:0] rgb;
        logic hs;
        logic vs;
        logic de;
        logic ctl;
        logic [3:0] gpio;
        logic [2:0] audio;
    } ssg_fwd_word_s;

    typedef struct packed {
        logic [3:0] sync;
        logic [3:0] gpio;
        logic irq_n;
        logic [2:0] ctl;
        logic [3:0] crc;
    } ssg_bc_frame_s;

    typedef enum logic [0:0] {
        BC_HUNT = 1'b0,
        BC_LOCK = 1'b1
    } ssg_bc_state_e;

    function automatic logic [3:0] ssg_bc_crc(input ssg_bc_frame_s f);
        ssg_bc_crc = f.sync ^ f.gpio ^ {f.irq_n, f.ctl};
    endfunction
endpackage

// [testbench/ssg_far_end.sv]
// far end model sending back channel frames
`timescale 1ns/10ps
`default_nettype none
module ssg_far_end (
    // back channel pins
    output logic bc_clk,
    output logic bc_data
);
    initial
    begin
        bc_clk = 1'b0;
        bc_data = 1'b0;
    end
    task automatic send(input logic [3:0] gp, input logic irq_n, input logic bad);
        ssg_pkg::ssg_bc_frame_s f;
        f.sync = ssg_pkg::BC_SYNC;
        f.gpio = gp;
        f.irq_n = irq_n;
        f.ctl = 3'h0;
        f.crc = f.sync ^ f.gpio ^ {f.irq_n, f.ctl} ^ {3'h0, bad};
        for (int i = 15; i >= 0; i--)
        begin
            bc_data = f[i];
            #80 bc_clk = 1'b1;
            #80 bc_clk = 1'b0;
        end
        // no pull on the line, so never leave the last bit standing
        bc_data = ~bc_data;
    endtask
endmodule
`default_nettype wire

// [testbench/ssg_sideband_bench.sv]
// self-checking bench for the sideband block
`timescale 1ns/10ps
`default_nettype none
module ssg_sideband_bench;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic power_down_input_n = 1'b1;
    logic src_5v_present = 1'b0;
    bit fwd_on = 1'b0;
    logic [15:0] lf = ssg_pkg::LFSR_SEED;
    logic pix_clk = 1'b0;
    logic [30:0] pay = 31'h0;
    logic [2:0] flt = 3'h0;
    logic [3:0] gpio_in = 4'h0;
    logic [3:0] regpin_in = 4'h0;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic bc_clk, bc_data, fwd_valid, irq_out_n, far_irq_mirror, reg_rvalid, hpd_out, hpd_oe;
    logic [3:0] gpio_out, gpio_oe, regpin_out, regpin_oe, aud_sel;
    logic [3:0] md[3] = '{4'h1, 4'h9, 4'h3};
    logic [7:0] reg_rdata;
    logic [7:0] exp_q[$];
    ssg_pkg::ssg_fwd_word_s fwd_word;
    int n_errors = 0;
    int n_compared = 0;
    int seed = 67;
    int cycles = 0;
    int n_fwd = 0;
    always #5 sys_clk = ~sys_clk;
    always #80 pix_clk = ~pix_clk;
    always @(posedge sys_clk) #1 pay = 31'($random(seed));
    ssg_far_end fe (.bc_clk, .bc_data);
    ssg_sideband dut (.sys_clk, .rst, .power_down_input_n, .src_5v_present, .pix_clk,
        .pix_rgb(pay[30:7]), .pix_hs(pay[6]), .pix_vs(pay[5]), .pix_de(pay[4]),
        .ctl_bus_bit(pay[3]), .audio_bits(pay[2:0]), .fwd_word, .fwd_valid, .bc_clk, .bc_data,
        .cable_open(flt[0]), .line_short(flt[1]), .polarity_bad(flt[2]), .gpio_in, .gpio_out,
        .gpio_oe, .regpin_in, .regpin_out, .regpin_oe, .regpin_audio_sel(aud_sel),
        .hot_plug_line_in(~hpd_oe), .hot_plug_line_out(hpd_out), .hot_plug_line_oe(hpd_oe),
        .irq_out_n, .far_irq_mirror, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata,
        .reg_rvalid);
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            n_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        step(1);
        reg_wr = 1'b0;
        step(1);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        reg_addr = a;
        reg_rd = 1'b1;
        exp_q.push_back(e);
        step(1);
        reg_rd = 1'b0;
        step(1);
    endtask
    task automatic fin(input string s);
        $display("test %s done", s);
    endtask
    task automatic end_of_test();
        $display("compared %0d, errors %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    always @(posedge sys_clk)
    begin
        cycles++;
        if (fwd_valid === 1'b1)
        begin
            n_fwd++;
            // only the pin field is predictable; video inputs change every cycle
            if (fwd_on)
                check(8'(fwd_word.gpio ^ lf[6:3]), {4'h0, gpio_in[3:1], 1'b0});
            lf = {lf[14:0], lf[15] ^ lf[13] ^ lf[12] ^ lf[10]};
        end
        if (reg_rvalid === 1'b1)
            check(reg_rdata, exp_q.size() > 0 ? exp_q.pop_front() : 8'hXX);
        if (cycles == 20000)
        begin
            n_errors++;
            $display("wrong value at %0t: run timed out", $time);
            end_of_test();
        end
    end
    initial
    begin
        step(6);
        rst = 1'b0;
        step(4);
        for (int i = 0; i < 5; i++)
            rd(8'h0D + 8'(i), 8'h00);
        rd(8'hC6, 8'h00);
        rd(8'h55, 8'h00);
        check(8'({aud_sel, hpd_oe}), 8'h1F);
        src_5v_present = 1'b1;
        for (int i = 0; i < 5; i++)
        begin
            reg_wdata = 8'($random(seed));
            wr(8'h0D + 8'(i), reg_wdata);
            rd(8'h0D + 8'(i), reg_wdata);
        end
        fin("registers");
        foreach (md[i])
        begin
            wr(8'h0D, {4'h0, md[i]});
            wr(8'h10, {4'h0, md[i]});
            step(3);
            check(8'({gpio_oe[0], gpio_out[0], regpin_oe[0], regpin_out[0], aud_sel[0]}),
                8'({md[i] != 4'h3, md[i] == 4'h9, md[i] != 4'h3, md[i] == 4'h9, 1'b0}));
        end
        fin("pin modes");
        for (int i = 0; i < 5; i++)
            wr(8'h0D + 8'(i), 8'h33);
        gpio_in = 4'($random(seed));
        regpin_in = 4'($random(seed));
        step(5);
        rd(8'h1C, {regpin_in[2:0], 1'b0, gpio_in});
        rd(8'h1D, {7'h0, regpin_in[3]});
        fin("input levels");
        wr(8'h0D, 8'h05);
        wr(8'hC6, 8'h21);
        fe.send(4'h1, 1'b1, 1'b0);
        fe.send(4'h1, 1'b0, 1'b0);
        step(8);
        check(8'({irq_out_n, far_irq_mirror, gpio_oe[0], gpio_out[0]}), 8'h03);
        rd(8'hC7, 8'h20);
        step(3);
        check(8'({irq_out_n, far_irq_mirror}), 8'h02);
        fe.send(4'h0, 1'b1, 1'b1);
        step(8);
        fe.send(4'h0, 1'b0, 1'b0);
        step(8);
        check(8'({irq_out_n, far_irq_mirror, gpio_out[0]}), 8'h04);
        fin("remote interrupt");
        for (int i = 0; i < 3; i++)
        begin
            flt = 3'(1 << i);
            step(10);
            rd(8'h0C, 8'h00);
            check(8'({far_irq_mirror, hpd_oe}), 8'h03);
        end
        flt = 3'h0;
        step(10);
        rd(8'h0C, 8'h03);
        wr(8'hC6, 8'h03);
        flt = 3'h1;
        step(10);
        check(8'(irq_out_n), 8'h00);
        rd(8'hC7, 8'h02);
        step(3);
        check(8'(irq_out_n), 8'h01);
        flt = 3'h0;
        fin("link fault");
        n_fwd = 0;
        fwd_on = 1'b1;
        step(160);
        fwd_on = 1'b0;
        check(8'(n_fwd), 8'd10);
        fin("forward words");
        wr(8'h0D, 8'h09);
        power_down_input_n = 1'b0;
        step(10);
        power_down_input_n = 1'b1;
        step(5);
        rd(8'h0D, 8'h00);
        rd(8'hC6, 8'h00);
        fin("power down");
        step(4);
        check(8'(exp_q.size()), 8'h00);
        end_of_test();
    end
endmodule
`default_nettype wire

// [testbench/ssg_sideband_props.sv]
// port checker for the sideband block
`timescale 1ns/10ps
`default_nettype none
module ssg_sideband_props (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // inputs
    input wire logic power_down_input_n,
    input wire logic cable_open,
    input wire logic line_short,
    input wire logic polarity_bad,
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_wdata,
    // outputs
    input wire logic reg_rvalid,
    input wire logic irq_out_n,
    input wire logic far_irq_mirror,
    input wire logic fwd_valid,
    input wire logic [3:0] gpio_out,
    input wire logic [3:0] gpio_oe,
    input wire logic [3:0] regpin_out,
    input wire logic [3:0] regpin_oe,
    input wire logic hot_plug_line_out,
    input wire logic hot_plug_line_oe
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    logic [5:0] pdn_hist;
    logic [5:0] next_pdn_hist;
    logic up;
    logic rd_stat;
    logic fault;
    // power-down reaches the logic through a synchroniser, so wait it out
    assign next_pdn_hist = {pdn_hist[4:0], power_down_input_n};
    assign up = &pdn_hist;
    assign rd_stat = reg_rd && reg_addr == ssg_pkg::ADDR_IRQ_STAT;
    assign fault = cable_open || line_short || polarity_bad;
    always_ff @(posedge sys_clk)
        pdn_hist <= next_pdn_hist;
    a_rd_answer: assert property (up && reg_rd |=> reg_rvalid)
        else $error("read not answered");
    a_irq_release: assert property (up && !$past(rst) && $rose(irq_out_n) |-> $past(rd_stat, 2))
        else $error("interrupt released without status read");
    a_mode_high: assert property (up && reg_wr && reg_addr == ssg_pkg::ADDR_PIN0_MODE
        && reg_wdata[3:0] == ssg_pkg::MODE_OUT_HIGH |-> ##[1:3] gpio_oe[0] && gpio_out[0])
        else $error("pin not driven high");
    a_regpin_low: assert property (up && reg_wr && reg_addr == ssg_pkg::ADDR_REGPIN56
        && reg_wdata[3:0] == ssg_pkg::MODE_OUT_LOW |-> ##[1:3] regpin_oe[0] && !regpin_out[0])
        else $error("register pin not driven low");
    a_fwd_pulse: assert property (fwd_valid |=> !fwd_valid)
        else $error("forward word strobe too long");
    a_fault_mirror: assert property (fault [*8] |-> far_irq_mirror)
        else $error("mirror low without link");
    a_pd_quiet: assert property ((!power_down_input_n) [*5] |-> irq_out_n
        && gpio_oe == 4'h0 && regpin_oe == 4'h0)
        else $error("outputs active in power-down");
    a_hpd_hold: assert property (fault [*8] |-> hot_plug_line_oe && !hot_plug_line_out)
        else $error("hot plug released on fault");
    c_irq: cover property (!irq_out_n);
    c_mirror: cover property ($fell(far_irq_mirror));
    c_fwd: cover property (fwd_valid);
endmodule
bind ssg_sideband ssg_sideband_props u_props (.sys_clk, .rst, .power_down_input_n, .cable_open,
    .line_short, .polarity_bad, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rvalid, .irq_out_n,
    .far_irq_mirror, .fwd_valid, .gpio_out, .gpio_oe, .regpin_out, .regpin_oe,
    .hot_plug_line_out, .hot_plug_line_oe);
`default_nettype wire

// [verilog/ssg_bc_deframer.sv]
// back channel frame recovery from sampled serial bits
`timescale 1ns/10ps
`default_nettype none
module ssg_bc_deframer (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // sampled serial bits
    input wire logic bit_tick,
    input wire logic bit_val,
    // recovered frame
    output ssg_pkg::ssg_bc_frame_s frame,
    output logic frame_ok,
    output logic crc_err
);
    ssg_pkg::ssg_bc_state_e state, next_state;
    logic [15:0] shift, next_shift;
    logic [4:0] cnt, next_cnt;
    ssg_pkg::ssg_bc_frame_s next_frame;
    logic next_ok, next_err;
    ssg_pkg::ssg_bc_frame_s win;

    always_comb
    begin
        win = ssg_pkg::ssg_bc_frame_s'({shift[14:0], bit_val});
        next_state = state;
        next_shift = shift;
        next_cnt = cnt;
        next_frame = frame;
        next_ok = 1'b0;
        next_err = 1'b0;
        if (bit_tick)
        begin
            next_shift = {shift[14:0], bit_val};
            unique case (state)
                ssg_pkg::BC_HUNT:
                begin
                    // sliding search; lock only on sync plus good check nibble
                    if (win.sync == ssg_pkg::BC_SYNC && win.crc == ssg_pkg::ssg_bc_crc(win))
                    begin
                        next_state = ssg_pkg::BC_LOCK;
                        next_frame = win;
                        next_ok = 1'b1;
                        next_cnt = 5'd0;
                    end
                end
                ssg_pkg::BC_LOCK:
                begin
                    next_cnt = cnt + 5'd1;
                    if (cnt == ssg_pkg::BC_CNT_LAST)
                    begin
                        next_cnt = 5'd0;
                        if (win.sync == ssg_pkg::BC_SYNC && win.crc == ssg_pkg::ssg_bc_crc(win))
                        begin
                            next_frame = win;
                            next_ok = 1'b1;
                        end
                        else
                        begin
                            // bad frame drops lock so alignment is searched again
                            next_err = 1'b1;
                            next_state = ssg_pkg::BC_HUNT;
                        end
                    end
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            state <= ssg_pkg::BC_HUNT;
            shift <= 16'h0000;
            cnt <= 5'd0;
            frame <= '0;
            frame_ok <= 1'b0;
            crc_err <= 1'b0;
        end
        else
        begin
            state <= next_state;
            shift <= next_shift;
            cnt <= next_cnt;
            frame <= next_frame;
            frame_ok <= next_ok;
            crc_err <= next_err;
        end
    end
endmodule
`default_nettype wire

// [verilog/ssg_sideband.sv]
// sideband control: pins, interrupts, link status, forward and back channel framing
// Contract
// - each pixel clock sends one scrambled 35-bit forward word with video, control, pins, audio
// - pixel clock 25 to 96 MHz on one lane, forward rate up to 3.36 Gbps; code forwards only pixel clocks well below sys_clk
// - back-channel frames carry control, check nibble and four pin bits; far end sets rate
// - power-down input low enters power-down and restores every control register default
// - link-detect status bit 0 of 0x0C reads 0 on a link fault
// - open, short, ground, battery or reversed line all flag one undistinguished fault
// - interrupt output low for enabled local or remote conditions set in 0xC6/0xC7
// - enabled remote interrupt low over back channel pulls interrupt output low
// - reading the interrupt status register clears pending interrupt, releases output
// - far interrupt mirror follows remote level, reads high when no link exists
// - link pins: 4-bit mode, 0x3 samples input forward, 0x5 drives from back channel
// - local modes: 0x1 drive low, 0x9 drive high, 0x3 input shown in 0x1C/0x1D
// - register-only pins override shared audio inputs when enabled
// - register-only pin state local or remote register access only, never over link
// - hot-plug line held low until ready, then released to pull high
// - link pins act as forward inputs or back-channel outputs per pin
`timescale 1ns/10ps
`default_nettype none
module ssg_sideband (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // power and source presence
    input wire logic power_down_input_n,
    input wire logic src_5v_present,
    // pixel side
    input wire logic pix_clk,
    input wire logic [23:0] pix_rgb,
    input wire logic pix_hs,
    input wire logic pix_vs,
    input wire logic pix_de,
    input wire logic ctl_bus_bit,
    input wire logic [2:0] audio_bits,
    // forward channel
    output ssg_pkg::ssg_fwd_word_s fwd_word,
    output logic fwd_valid,
    // back channel
    input wire logic bc_clk,
    input wire logic bc_data,
    // line fault detectors
    input wire logic cable_open,
    input wire logic line_short,
    input wire logic polarity_bad,
    // link-transported pins
    input wire logic [3:0] gpio_in,
    output logic [3:0] gpio_out,
    output logic [3:0] gpio_oe,
    // register-only pins shared with audio
    input wire logic [3:0] regpin_in,
    output logic [3:0] regpin_out,
    output logic [3:0] regpin_oe,
    output logic [3:0] regpin_audio_sel,
    // hot plug, open drain
    input wire logic hot_plug_line_in,
    output logic hot_plug_line_out,
    output logic hot_plug_line_oe,
    // interrupts
    output logic irq_out_n,
    output logic far_irq_mirror,
    // register access
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    output logic reg_rvalid
);
    // drive decode shared by link pins and register-only pins
    function automatic logic [1:0] pin_drive(input logic [3:0] mode, input logic bc_val,
                                             input logic link_pin);
        pin_drive = 2'b00;
        if (mode == ssg_pkg::MODE_OUT_LOW)
            pin_drive = 2'b10;
        else if (mode == ssg_pkg::MODE_OUT_HIGH)
            pin_drive = 2'b11;
        else if (link_pin && mode == ssg_pkg::MODE_FROM_BACK)
            pin_drive = {1'b1, bc_val};
    endfunction

    // pin synchronisers
    logic [ssg_pkg::SYNC_W-1:0] sync_a, sync_b;
    logic pix_prev, bcc_prev;
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            sync_a <= '0;
            sync_b <= '0;
            pix_prev <= 1'b0;
            bcc_prev <= 1'b0;
        end
        else
        begin
            sync_a <= {power_down_input_n, src_5v_present, pix_clk, bc_clk, bc_data,
                       hot_plug_line_in, gpio_in, regpin_in, cable_open, line_short,
                       polarity_bad, pix_rgb, pix_hs, pix_vs, pix_de, ctl_bus_bit, audio_bits};
            sync_b <= sync_a;
            pix_prev <= sync_b[45];
            bcc_prev <= sync_b[44];
        end
    end
    logic pdn_s, src5_s, pix_s, bcc_s, bcd_s, hpd_s, fault_s;
    logic [3:0] gpio_s, regpin_s;
    ssg_pkg::ssg_fwd_word_s vid_s;
    assign pdn_s = sync_b[47];
    assign src5_s = sync_b[46];
    assign pix_s = sync_b[45];
    assign bcc_s = sync_b[44];
    assign bcd_s = sync_b[43];
    assign hpd_s = sync_b[42];
    assign gpio_s = sync_b[41:38];
    assign regpin_s = sync_b[37:34];
    assign fault_s = |sync_b[33:31];
    assign vid_s = ssg_pkg::ssg_fwd_word_s'({sync_b[30:3], 4'h0, sync_b[2:0]});

    // power-down acts as a reset of all control state
    logic pd_rst;
    assign pd_rst = rst | ~pdn_s;

    // back channel
    ssg_pkg::ssg_bc_frame_s bc_frame;
    logic bc_ok;
    ssg_bc_deframer u_deframer (
        .sys_clk(sys_clk),
        .rst(pd_rst),
        .bit_tick(bcc_s & ~bcc_prev),
        .bit_val(bcd_s),
        .frame(bc_frame),
        .frame_ok(bc_ok),
        .crc_err()
    );

    // registers
    logic [7:0] mode0, mode12, mode3, rmode56, rmode78, irq_ctl, irq_stat;
    logic [7:0] next_mode0, next_mode12, next_mode3, next_rmode56, next_rmode78;
    logic [7:0] next_irq_ctl, next_irq_stat, next_rdata;
    logic next_rvalid;
    logic [3:0] bc_gpio, next_bc_gpio;
    logic far_irq_n, next_far_irq_n;
    logic [ssg_pkg::BC_LOSS_W-1:0] alive_cnt, next_alive_cnt;
    logic link_det, next_link_det;
    logic [3:0] lmode [4];
    logic [3:0] rmode [4];
    logic linked, remote_fall, link_drop;
    logic [7:0] lvl_lo, lvl_hi;

    always_comb
    begin
        lmode[0] = mode0[3:0];
        lmode[1] = mode12[3:0];
        lmode[2] = mode12[7:4];
        lmode[3] = mode3[3:0];
        rmode[0] = rmode56[3:0];
        rmode[1] = rmode56[7:4];
        rmode[2] = rmode78[3:0];
        rmode[3] = rmode78[7:4];
    end

    assign linked = link_det && alive_cnt != '0;
    // state of register-only pins goes nowhere but these bits
    assign lvl_lo = {regpin_s[2:0], 1'b0, gpio_s};
    assign lvl_hi = {7'h00, regpin_s[3]};
    assign remote_fall = bc_ok && linked && far_irq_n && !bc_frame.irq_n;
    assign link_drop = link_det && fault_s;

    always_comb
    begin
        next_mode0 = mode0;
        next_mode12 = mode12;
        next_mode3 = mode3;
        next_rmode56 = rmode56;
        next_rmode78 = rmode78;
        next_irq_ctl = irq_ctl;
        next_irq_stat = irq_stat;
        next_rdata = 8'h00;
        next_rvalid = 1'b0;
        next_bc_gpio = bc_gpio;
        next_far_irq_n = far_irq_n;
        next_link_det = ~fault_s;
        next_alive_cnt = alive_cnt;
        if (bc_ok)
        begin
            next_bc_gpio = bc_frame.gpio;
            next_far_irq_n = bc_frame.irq_n;
            next_alive_cnt = ssg_pkg::BC_LOSS_W'(ssg_pkg::BC_LOSS_CYC);
        end
        else if (alive_cnt != '0)
            next_alive_cnt = alive_cnt - 1'b1;
        if (reg_wr)
        begin
            unique case (reg_addr)
                ssg_pkg::ADDR_PIN0_MODE: next_mode0 = reg_wdata;
                ssg_pkg::ADDR_PIN12_MODE: next_mode12 = reg_wdata;
                ssg_pkg::ADDR_PIN3_MODE: next_mode3 = reg_wdata;
                ssg_pkg::ADDR_REGPIN56: next_rmode56 = reg_wdata;
                ssg_pkg::ADDR_REGPIN78: next_rmode78 = reg_wdata;
                ssg_pkg::ADDR_IRQ_CTL: next_irq_ctl = reg_wdata;
                default: next_mode0 = mode0;
            endcase
        end
        if (reg_rd)
        begin
            next_rvalid = 1'b1;
            unique case (reg_addr)
                ssg_pkg::ADDR_LINK_STAT:
                    next_rdata = {6'h00, hpd_s, link_det};
                ssg_pkg::ADDR_PIN0_MODE: next_rdata = mode0;
                ssg_pkg::ADDR_PIN12_MODE: next_rdata = mode12;
                ssg_pkg::ADDR_PIN3_MODE: next_rdata = mode3;
                ssg_pkg::ADDR_REGPIN56: next_rdata = rmode56;
                ssg_pkg::ADDR_REGPIN78: next_rdata = rmode78;
                ssg_pkg::ADDR_IN_LVL_LO: next_rdata = lvl_lo;
                ssg_pkg::ADDR_IN_LVL_HI: next_rdata = lvl_hi;
                ssg_pkg::ADDR_IRQ_CTL: next_rdata = irq_ctl;
                ssg_pkg::ADDR_IRQ_STAT:
                begin
                    next_rdata = irq_stat;
                    next_irq_stat = 8'h00;
                end
                default: next_rdata = 8'h00;
            endcase
        end
        // sticky until read, and a new event beats a same-cycle read
        if (remote_fall && irq_ctl[ssg_pkg::BIT_IRQ_GLOBAL] && irq_ctl[ssg_pkg::BIT_IRQ_REMOTE])
            next_irq_stat[ssg_pkg::BIT_IRQ_REMOTE] = 1'b1;
        if (link_drop && irq_ctl[ssg_pkg::BIT_IRQ_GLOBAL] && irq_ctl[ssg_pkg::BIT_IRQ_LINK])
            next_irq_stat[ssg_pkg::BIT_IRQ_LINK] = 1'b1;
    end

    always_ff @(posedge sys_clk)
    begin
        if (pd_rst)
        begin
            mode0 <= ssg_pkg::RST_MODE;
            mode12 <= ssg_pkg::RST_MODE;
            mode3 <= ssg_pkg::RST_MODE;
            rmode56 <= ssg_pkg::RST_MODE;
            rmode78 <= ssg_pkg::RST_MODE;
            irq_ctl <= ssg_pkg::RST_IRQ_CTL;
            irq_stat <= 8'h00;
            reg_rdata <= 8'h00;
            reg_rvalid <= 1'b0;
            bc_gpio <= 4'h0;
            far_irq_n <= 1'b1;
            alive_cnt <= '0;
            link_det <= 1'b0;
        end
        else
        begin
            mode0 <= next_mode0;
            mode12 <= next_mode12;
            mode3 <= next_mode3;
            rmode56 <= next_rmode56;
            rmode78 <= next_rmode78;
            irq_ctl <= next_irq_ctl;
            irq_stat <= next_irq_stat;
            reg_rdata <= next_rdata;
            reg_rvalid <= next_rvalid;
            bc_gpio <= next_bc_gpio;
            far_irq_n <= next_far_irq_n;
            alive_cnt <= next_alive_cnt;
            link_det <= next_link_det;
        end
    end

    // pins, interrupt and hot-plug outputs
    logic [3:0] next_gpio_out, next_gpio_oe, next_regpin_out, next_regpin_oe, next_audio_sel;
    logic [3:0] fwd_gpio;
    logic [1:0] drv;
    logic next_irq_n, next_mirror, next_hpd_oe;
    always_comb
    begin
        drv = 2'b00;
        next_gpio_out = 4'h0;
        next_gpio_oe = 4'h0;
        next_regpin_out = 4'h0;
        next_regpin_oe = 4'h0;
        next_audio_sel = 4'h0;
        fwd_gpio = 4'h0;
        for (int i = 0; i < 4; i++)
        begin
            drv = pin_drive(lmode[i], bc_gpio[i], 1'b1);
            next_gpio_oe[i] = drv[1];
            next_gpio_out[i] = drv[0];
            fwd_gpio[i] = (lmode[i] == ssg_pkg::MODE_INPUT) && gpio_s[i];
            drv = pin_drive(rmode[i], 1'b0, 1'b0);
            next_regpin_oe[i] = drv[1];
            next_regpin_out[i] = drv[0];
            // audio keeps the pin unless a register-pin mode claims it
            next_audio_sel[i] = !(drv[1] || rmode[i] == ssg_pkg::MODE_INPUT);
        end
        next_irq_n = ~|irq_stat;
        next_mirror = linked ? far_irq_n : 1'b1;
        // hold low until powered, source 5 V seen and link good
        next_hpd_oe = !(src5_s && link_det);
    end

    always_ff @(posedge sys_clk)
    begin
        if (pd_rst)
        begin
            gpio_out <= 4'h0;
            gpio_oe <= 4'h0;
            regpin_out <= 4'h0;
            regpin_oe <= 4'h0;
            regpin_audio_sel <= 4'hF;
            irq_out_n <= 1'b1;
            far_irq_mirror <= 1'b1;
            hot_plug_line_out <= 1'b0;
            hot_plug_line_oe <= 1'b1;
        end
        else
        begin
            gpio_out <= next_gpio_out;
            gpio_oe <= next_gpio_oe;
            regpin_out <= next_regpin_out;
            regpin_oe <= next_regpin_oe;
            regpin_audio_sel <= next_audio_sel;
            irq_out_n <= next_irq_n;
            far_irq_mirror <= next_mirror;
            hot_plug_line_out <= 1'b0;
            hot_plug_line_oe <= next_hpd_oe;
        end
    end

    // forward word, one per pixel clock rising edge
    logic [15:0] lfsr, next_lfsr;
    ssg_pkg::ssg_fwd_word_s next_fwd, payload;
    logic next_fwd_valid;
    always_comb
    begin
        payload = vid_s;
        payload.gpio = fwd_gpio;
        next_lfsr = lfsr;
        next_fwd = fwd_word;
        next_fwd_valid = 1'b0;
        if (pix_s && !pix_prev)
        begin
            // edge sampling limits usable pixel clock to well below the system clock
            next_fwd = payload ^ ssg_pkg::ssg_fwd_word_s'({lfsr[2:0], lfsr, lfsr});
            next_fwd_valid = 1'b1;
            next_lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (pd_rst)
        begin
            lfsr <= ssg_pkg::LFSR_SEED;
            fwd_word <= '0;
            fwd_valid <= 1'b0;
        end
        else
        begin
            lfsr <= next_lfsr;
            fwd_word <= next_fwd;
            fwd_valid <= next_fwd_valid;
        end
    end
endmodule
`default_nettype wire
